// *** rtl/serial_tx_pkg.sv ***
// Shared constants, configuration carrier and state encoding for the transmitter.
package serial_tx_pkg;

  // Frame shape.
  localparam int unsigned DATA_BITS = 8;
  localparam logic [2:0] LAST_DATA_IDX = 3'h7;

  // Basic clock runs at sixteen times the bit rate.
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [3:0] LAST_SUB_TICK = 4'hF;

  // Prescale masks applied before the rate count, per clock selector n.
  // With the sixteenfold basic clock these give phi/32, phi/128, phi/512
  // and phi/2048 per (N+1).
  localparam logic [6:0] PRESC_MASK_N0 = 7'h01;
  localparam logic [6:0] PRESC_MASK_N1 = 7'h07;
  localparam logic [6:0] PRESC_MASK_N2 = 7'h1F;
  localparam logic [6:0] PRESC_MASK_N3 = 7'h7F;

  // Reset values.
  localparam logic EMPTY_FLAG_RST = 1'b1;
  localparam logic END_FLAG_RST = 1'b1;
  localparam logic LINE_MARK = 1'b1;
  localparam logic LINE_SPACE = 1'b0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [6:0] PRESC_RST = 7'h00;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [3:0] SUB_RST = 4'h0;
  localparam logic [2:0] IDX_RST = 3'h0;

  // Configuration bits driven by the control logic of the CPU side.
  typedef struct packed {
    logic tx_enable;         // Transmitter enabled.
    logic tx_irq_enable;     // Data-empty request enable.
    logic tx_end_irq_enable; // Transmit-end request enable.
    logic parity_enable;     // Send a parity bit after the data.
    logic parity_odd;        // Odd parity when set, even when clear.
    logic [1:0] clk_sel;     // Clock-source selector n.
    logic [7:0] bit_rate_count; // Rate count N.
  } serial_cfg_s;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_START  = 3'b001,
    ST_DATA   = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP   = 3'b100
  } tx_state_e;

endpackage

// *** rtl/async_serial_transmitter.sv ***
// Asynchronous serial transmitter with holding and shift registers.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - While the empty flag is 0, the holding byte moves into the shift register.
// - After that move the empty flag goes to 1 and the frame starts.
// - Data-empty request is raised while the empty flag and its enable are 1.
// - The empty flag is sampled as the stop bit is about to go out.
// - Flag 0 at stop time: load next byte, send stop, start next frame.
// - Flag 1 at stop time: set the transmit-end flag, then send stop.
// - With nothing pending after the stop bit the line idles high.
// - Transmit-end request is raised while that flag and its enable are 1.
// - Frames carry eight data bits, a parity bit when parity_enable is set, and one stop bit.
// - Bit rate comes from selector n (0 to 3) and eight-bit count N.
// - Logic runs from a basic clock at sixteen times the bit rate.
// - Each bit lasts sixteen basic ticks so a receiver samples at tick eight.
module async_serial_transmitter (
  input wire logic clk_sys, // System clock, 40 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire serial_tx_pkg::serial_cfg_s cfg, // Control and rate settings.
  input wire logic hold_wr, // One-cycle write strobe of the holding register.
  input wire logic [7:0] hold_wr_data, // Byte written with the strobe.
  output logic tx_line, // Serial output, high when idle.
  output logic tx_data_empty_flag, // Holding register free for a new byte.
  output logic tx_end_flag, // Last frame finished with nothing pending.
  output logic tx_empty_irq, // Data-empty interrupt request, level.
  output logic tx_end_irq, // Transmit-end interrupt request, level.
  output logic tx_busy // A frame is being shifted out.
);

  serial_tx_pkg::tx_state_e state_q;
  serial_tx_pkg::tx_state_e state_d;

  logic [7:0] tx_holding_reg_q;
  logic [7:0] tx_shift_reg_q;
  logic parity_q;
  logic empty_q;
  logic end_q;
  logic line_q;
  logic [6:0] presc_q;
  logic [7:0] rate_q;
  logic [3:0] sub_q;
  logic [2:0] idx_q;
  logic chain_q;

  logic presc_tick;
  logic basic_tick;
  logic bit_end;
  logic stop_entry;
  logic idle_load;
  logic load;
  logic [7:0] load_byte;

  // Prescale mask for selector n; n=3 is treated as the next step up.
  function automatic logic [6:0] presc_mask(input logic [1:0] sel);
    logic [6:0] m;
    m = serial_tx_pkg::PRESC_MASK_N0;
    case (sel)
      2'h0: m = serial_tx_pkg::PRESC_MASK_N0;
      2'h1: m = serial_tx_pkg::PRESC_MASK_N1;
      2'h2: m = serial_tx_pkg::PRESC_MASK_N2;
      2'h3: m = serial_tx_pkg::PRESC_MASK_N3;
      default: m = serial_tx_pkg::PRESC_MASK_N0;
    endcase
    return m;
  endfunction

  // Even parity of a byte, inverted for odd parity.
  function automatic logic parity_of(input logic [7:0] b, input logic odd);
    return (^b) ^ odd;
  endfunction

  // A byte written in the same cycle as a move is taken straight through,
  // so a late write at stop time is not lost.
  assign load_byte = hold_wr ? hold_wr_data : tx_holding_reg_q;

  // A move is made only when the empty flag reads 0 or a write lands now.
  assign idle_load = (state_q == serial_tx_pkg::ST_IDLE) && cfg.tx_enable &&
                     (!empty_q || hold_wr);
  assign load = idle_load || (stop_entry && (!empty_q || hold_wr));

  // Dividers stay cleared while idle so the first start bit is full length.
  assign presc_tick = (presc_q & presc_mask(cfg.clk_sel)) ==
                      presc_mask(cfg.clk_sel);
  assign basic_tick = presc_tick && (rate_q == cfg.bit_rate_count);
  assign bit_end = basic_tick && (sub_q == serial_tx_pkg::LAST_SUB_TICK);

  // The stop bit is about to go out when parity (or the last data bit
  // without parity) ends.
  assign stop_entry = bit_end &&
    ((state_q == serial_tx_pkg::ST_PARITY) ||
     (state_q == serial_tx_pkg::ST_DATA && !cfg.parity_enable &&
      idx_q == serial_tx_pkg::LAST_DATA_IDX));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= serial_tx_pkg::PRESC_RST;
    end else if (state_q == serial_tx_pkg::ST_IDLE) begin
      presc_q <= serial_tx_pkg::PRESC_RST;
    end else begin
      presc_q <= presc_q + 7'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rate_q <= serial_tx_pkg::RATE_RST;
    end else if (state_q == serial_tx_pkg::ST_IDLE || basic_tick) begin
      rate_q <= serial_tx_pkg::RATE_RST;
    end else if (presc_tick) begin
      rate_q <= rate_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sub_q <= serial_tx_pkg::SUB_RST;
    end else if (state_q == serial_tx_pkg::ST_IDLE) begin
      sub_q <= serial_tx_pkg::SUB_RST;
    end else if (basic_tick) begin
      sub_q <= sub_q + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_holding_reg_q <= serial_tx_pkg::BYTE_RST;
    end else if (hold_wr) begin
      tx_holding_reg_q <= hold_wr_data;
    end
  end

  // Set by a move wins over the clear of a write in the same cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      empty_q <= serial_tx_pkg::EMPTY_FLAG_RST;
    end else if (load) begin
      empty_q <= 1'b1;
    end else if (hold_wr) begin
      empty_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      end_q <= serial_tx_pkg::END_FLAG_RST;
    end else if (stop_entry && empty_q && !hold_wr) begin
      end_q <= 1'b1;
    end else if (hold_wr || idle_load) begin
      end_q <= 1'b0;
    end
  end

  // Remembers a move at stop entry. The flags cannot stand in for it,
  // because a write during the stop bit changes both of them.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chain_q <= 1'b0;
    end else if (stop_entry) begin
      chain_q <= load;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_reg_q <= serial_tx_pkg::BYTE_RST;
      parity_q <= 1'b0;
    end else if (load) begin
      tx_shift_reg_q <= load_byte;
      parity_q <= parity_of(load_byte, cfg.parity_odd);
    end else if (state_q == serial_tx_pkg::ST_DATA && bit_end) begin
      tx_shift_reg_q <= {1'b0, tx_shift_reg_q[7:1]};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= serial_tx_pkg::IDX_RST;
    end else if (state_q != serial_tx_pkg::ST_DATA) begin
      idx_q <= serial_tx_pkg::IDX_RST;
    end else if (bit_end) begin
      idx_q <= idx_q + 3'h1;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      serial_tx_pkg::ST_IDLE: begin
        if (idle_load) begin
          state_d = serial_tx_pkg::ST_START;
        end
      end
      serial_tx_pkg::ST_START: begin
        if (bit_end) begin
          state_d = serial_tx_pkg::ST_DATA;
        end
      end
      serial_tx_pkg::ST_DATA: begin
        if (bit_end && idx_q == serial_tx_pkg::LAST_DATA_IDX) begin
          state_d = cfg.parity_enable ? serial_tx_pkg::ST_PARITY
                                      : serial_tx_pkg::ST_STOP;
        end
      end
      serial_tx_pkg::ST_PARITY: begin
        if (bit_end) begin
          state_d = serial_tx_pkg::ST_STOP;
        end
      end
      serial_tx_pkg::ST_STOP: begin
        // A byte loaded at stop entry follows with no idle gap.
        if (bit_end) begin
          state_d = chain_q ? serial_tx_pkg::ST_START
                            : serial_tx_pkg::ST_IDLE;
        end
      end
      default: state_d = serial_tx_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= serial_tx_pkg::ST_IDLE;
    end else if (!cfg.tx_enable) begin
      state_q <= serial_tx_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // The line follows the state one cycle later; every edge shares that delay.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_q <= serial_tx_pkg::LINE_MARK;
    end else begin
      unique case (state_q)
        serial_tx_pkg::ST_START: line_q <= serial_tx_pkg::LINE_SPACE;
        serial_tx_pkg::ST_DATA: line_q <= tx_shift_reg_q[0];
        serial_tx_pkg::ST_PARITY: line_q <= parity_q;
        serial_tx_pkg::ST_STOP: line_q <= serial_tx_pkg::LINE_MARK;
        serial_tx_pkg::ST_IDLE: line_q <= serial_tx_pkg::LINE_MARK;
        default: line_q <= serial_tx_pkg::LINE_MARK;
      endcase
    end
  end

  assign tx_line = line_q;
  assign tx_data_empty_flag = empty_q;
  assign tx_end_flag = end_q;
  assign tx_empty_irq = empty_q && cfg.tx_irq_enable;
  assign tx_end_irq = end_q && cfg.tx_end_irq_enable;
  assign tx_busy = (state_q != serial_tx_pkg::ST_IDLE);

endmodule

`default_nettype wire

// *** verif/serial_tx_assertions.sv ***
// Concurrent checks on the transmitter ports, bound to the top module.
`timescale 1ns/10ps
`default_nettype none
module serial_tx_checker (
  input wire logic clk_sys, // Clock.
  input wire logic rst_n, // Reset, active low.
  input wire serial_tx_pkg::serial_cfg_s cfg, // Settings.
  input wire logic hold_wr, // Write strobe.
  input wire logic [7:0] hold_wr_data, // Write data.
  input wire logic tx_line, // Serial out.
  input wire logic tx_data_empty_flag, // Empty flag.
  input wire logic tx_end_flag, // End flag.
  input wire logic tx_empty_irq, // Empty request.
  input wire logic tx_end_irq, // End request.
  input wire logic tx_busy // Busy.
);
  logic [31:0] b;
  logic [31:0] cnt_q;
  logic line_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  assign b = (32'h20 << (2 * cfg.clk_sel)) * (cfg.bit_rate_count + 32'h1);
  // Only low runs are timed, since idle high runs may have any length.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
      line_q <= 1'b1;
    end else begin
      cnt_q <= (tx_line != line_q) ? 32'h1 : cnt_q + 32'h1;
      line_q <= tx_line;
    end
  end
  sequence s_moved;
    tx_data_empty_flag && tx_busy && !tx_end_flag;
  endsequence
  sequence s_stop_out;
    tx_busy && tx_data_empty_flag ##1 tx_line;
  endsequence
  a_empty_irq_level: assert property (
    tx_empty_irq == (tx_data_empty_flag && cfg.tx_irq_enable))
    else $error("empty request does not follow flag and enable");
  a_end_irq_level: assert property (
    tx_end_irq == (tx_end_flag && cfg.tx_end_irq_enable))
    else $error("end request does not follow flag and enable");
  a_byte_moved: assert property (
    !tx_busy && cfg.tx_enable && !tx_data_empty_flag |=> s_moved)
    else $error("pending byte not moved from idle");
  a_write_pending: assert property (
    hold_wr && !tx_busy && !cfg.tx_enable |=> !tx_data_empty_flag)
    else $error("write did not clear empty flag");
  a_idle_write_moves: assert property (
    hold_wr && !tx_busy && cfg.tx_enable |=> s_moved)
    else $error("byte written in idle not moved at once");
  a_start_low: assert property (
    $rose(tx_busy) |=> !tx_line)
    else $error("frame did not begin with a low start bit");
  a_end_at_stop: assert property (
    $rose(tx_end_flag) |-> s_stop_out)
    else $error("end flag set outside the stop bit");
  a_end_holds: assert property (
    tx_end_flag && !hold_wr |=> tx_end_flag)
    else $error("end flag dropped without a write");
  a_idle_mark: assert property (
    !tx_busy |=> tx_line)
    else $error("line not high while idle");
  a_bit_length: assert property (
    $rose(tx_line) |-> (cnt_q % b) == 32'h0)
    else $error("low run is not a whole number of bits");
endmodule
bind async_serial_transmitter serial_tx_checker chk_i (.clk_sys(clk_sys),
  .rst_n(rst_n), .cfg(cfg), .hold_wr(hold_wr), .hold_wr_data(hold_wr_data),
  .tx_line(tx_line), .tx_data_empty_flag(tx_data_empty_flag),
  .tx_end_flag(tx_end_flag), .tx_empty_irq(tx_empty_irq),
  .tx_end_irq(tx_end_irq), .tx_busy(tx_busy));
`default_nettype wire

// *** verif/serial_rx_model.sv ***
// Behavioural far-end receiver that samples the line in mid-bit.
`timescale 1ns/10ps
`default_nettype none
module serial_rx_model (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic line, // Serial line watched.
  input wire logic [31:0] bit_cycles, // System cycles per bit.
  input wire logic par_en, // A parity bit is expected.
  output logic [7:0] rx_byte, // Last byte received.
  output logic rx_par, // Last parity bit.
  output logic rx_stop, // Last stop bit.
  output logic [31:0] rx_count // Frames received.
);
  initial begin
    rx_count = 32'h0;
    forever begin
      @(negedge line iff rst_n);
      repeat (bit_cycles / 2) @(posedge clk_sys);
      for (int i = 0; i < 9 + par_en; i++) begin
        repeat (bit_cycles) @(posedge clk_sys);
        if (i < 8) rx_byte[i] = line;
        else if (i == 8 && par_en) rx_par = line;
        else rx_stop = line;
      end
      rx_count = rx_count + 32'h1;
    end
  end
endmodule
`default_nettype wire

// *** verif/tb_async_serial_transmitter.sv ***
// Self-checking bench for the asynchronous serial transmitter.
`timescale 1ns/10ps
`default_nettype none
module tb_async_serial_transmitter;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  serial_tx_pkg::serial_cfg_s cfg = '0;
  logic hold_wr = 1'b0;
  logic [7:0] hold_wr_data = 8'h00;
  logic tx_line, empty_f, end_f, empty_irq, end_irq, busy, rx_par, rx_stop;
  logic [7:0] rx_byte;
  logic [31:0] rx_count, bit_cycles;
  logic [31:0] busy_cyc = 32'h0;
  logic [31:0] seed = 32'h6D8D1F8B;
  int err_total = 0;
  int checks_done = 0;
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) busy_cyc <= busy_cyc + (busy === 1'b1);
  async_serial_transmitter uut (.clk_sys(clk_sys), .rst_n(rst_n), .cfg(cfg),
    .hold_wr(hold_wr), .hold_wr_data(hold_wr_data), .tx_line(tx_line),
    .tx_data_empty_flag(empty_f), .tx_end_flag(end_f),
    .tx_empty_irq(empty_irq), .tx_end_irq(end_irq), .tx_busy(busy));
  serial_rx_model far (.clk_sys(clk_sys), .rst_n(rst_n), .line(tx_line),
    .bit_cycles(bit_cycles), .par_en(cfg.parity_enable), .rx_byte(rx_byte),
    .rx_par(rx_par), .rx_stop(rx_stop), .rx_count(rx_count));
  assign bit_cycles = (32'h20 << (2 * cfg.clk_sel)) * (cfg.bit_rate_count + 1);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic par(input logic [7:0] v, input logic odd);
    return ^v ^ odd;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Waiting on the empty flag paces writes ahead of each stop bit.
  task automatic wr(input logic [7:0] v);
    @(posedge clk_sys);
    hold_wr <= 1'b1;
    hold_wr_data <= v;
    @(posedge clk_sys);
    hold_wr <= 1'b0;
    @(negedge clk_sys);
    while (empty_f !== 1'b1) @(negedge clk_sys);
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    summarize();
  end
  initial begin
    logic [7:0] d [3];
    logic [31:0] base, cnt0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk("reset line", 1, tx_line);
    chk("reset empty", 1, empty_f);
    chk("reset end", 1, end_f);
    for (int m = 0; m < 4; m++) begin
      for (int i = 0; i < 3; i++) begin
        seed = lfsr(seed);
        d[i] = seed[7:0];
      end
      if (m == 0) d[0] = 8'h00;
      if (m == 3) d[0] = 8'hFF;
      @(posedge clk_sys);
      cfg <= '{1'b1, m[0], !m[0], m != 1, m == 2,
               (m == 3) ? 2'h0 : 2'(m), (m == 3) ? 8'h03 : 8'h00};
      @(negedge clk_sys);
      base = busy_cyc;
      cnt0 = rx_count;
      fork
        for (int i = 0; i < 3; i++) begin
          wr(d[i]);
          if (i == 0) chk("end cleared", 0, end_f);
        end
        for (int j = 0; j < 3; j++) begin
          wait (rx_count == cnt0 + j + 1);
          chk("rx byte", d[j], rx_byte);
          if (cfg.parity_enable)
            chk("rx parity", par(d[j], cfg.parity_odd), rx_par);
          chk("rx stop", 1, rx_stop);
        end
      join
      while (busy !== 1'b0) @(negedge clk_sys);
      chk("busy span", 3 * (10 + cfg.parity_enable) * bit_cycles,
          busy_cyc - base);
      chk("end set", 1, end_f);
      chk("idle line", 1, tx_line);
      chk("empty irq", cfg.tx_irq_enable, empty_irq);
      chk("end irq", cfg.tx_end_irq_enable, end_irq);
    end
    // A byte written while disabled waits for the enable, then goes out.
    @(posedge clk_sys);
    cfg.tx_enable <= 1'b0;
    hold_wr <= 1'b1;
    hold_wr_data <= 8'hA5;
    @(posedge clk_sys);
    hold_wr <= 1'b0;
    @(negedge clk_sys);
    chk("empty held", 0, empty_f);
    chk("end cleared", 0, end_f);
    cnt0 = rx_count;
    @(posedge clk_sys);
    cfg.tx_enable <= 1'b1;
    wait (rx_count == cnt0 + 1);
    chk("rx byte", 8'hA5, rx_byte);
    chk("rx parity", par(8'hA5, cfg.parity_odd), rx_par);
    while (busy !== 1'b0) @(negedge clk_sys);
    chk("end set", 1, end_f);
    summarize();
  end
endmodule
`default_nettype wire
